// ---- inc/ccr_pkg.sv ----
/*
 * ccr_pkg: register offsets, field positions, reset values and timing
 * constants of the converter control register bank.
 * Assumes a 50 MHz ref_clk; timer counts are derived from it here.
 */
package ccr_pkg;

   // register offsets
   localparam logic [7:0] OFS_STATUS = 8'h00;
   localparam logic [7:0] OFS_VIN = 8'h01;
   localparam logic [7:0] OFS_IIN = 8'h02;
   localparam logic [7:0] OFS_TEMP = 8'h03;
   localparam logic [7:0] OFS_CMD1 = 8'h04;
   localparam logic [7:0] OFS_CMD2 = 8'h05;
   localparam logic [7:0] OFS_CMD3 = 8'h06;
   localparam logic [7:0] OFS_SENSE1 = 8'h07;
   localparam logic [7:0] OFS_SENSE2 = 8'h08;
   localparam logic [7:0] OFS_EVENT = 8'h09;
   localparam logic [7:0] OFS_REV = 8'h0A;

   // reset values
   localparam logic [7:0] RST_CMD1 = 8'h73;
   localparam logic [7:0] RST_CMD2 = 8'h29;
   localparam logic [7:0] RST_CMD3_V25 = 8'h02;
   localparam logic [7:0] RST_CMD3_V18 = 8'h01;
   localparam logic [7:0] RST_ZERO = 8'h00;

   // field positions and masks
   localparam int CMD1_VTH_LSB = 0;
   localparam int CMD1_VCL_LSB = 4;
   localparam logic [7:0] CMD1_MASK = 8'h7F;
   localparam int CMD2_FORCE_BIT = 1;
   localparam int CMD2_CLKDIS_BIT = 2;
   localparam int CMD2_CONVD_LSB = 3;
   localparam int CMD2_DIV2_LSB = 5;
   localparam logic [7:0] CMD2_FIXED_ONE = 8'h01;
   localparam int CMD3_VSEL_LSB = 0;
   localparam int CMD3_CONVR_BIT = 2;
   localparam int CMD3_CONVM_BIT = 3;
   localparam logic [7:0] CMD3_MASK = 8'h0F;
   localparam int SENSE2_RATIO_LSB = 2;

   // status / sense bit positions
   localparam int ST_CHARGE = 0;
   localparam int ST_OVP = 1;
   localparam int ST_CONV = 2;
   localparam int ST_TSD = 3;
   localparam int ST_WARN = 4;
   localparam int ST_OC = 5;
   localparam int ST_VTH = 6;
   localparam int ST_CLAMP = 7;
   localparam logic [7:0] ADC_FULL_SCALE = 8'hFF;

   // conversion interval selections
   localparam logic [1:0] CONVD_10MS = 2'h0;
   localparam logic [1:0] CONVD_2MS = 2'h1;
   localparam logic [1:0] CONVD_1MS = 2'h2;
   localparam logic [1:0] CONVD_500US = 2'h3;

   // timing
   localparam int CLK_MHZ = 50;
   localparam int CONV_10MS_US = 10000;
   localparam int CONV_2MS_US = 2000;
   localparam int CONV_1MS_US = 1000;
   localparam int CONV_500US_US = 500;
   localparam int CONV_10MS_CYC = CONV_10MS_US * CLK_MHZ;
   localparam int CONV_2MS_CYC = CONV_2MS_US * CLK_MHZ;
   localparam int CONV_1MS_CYC = CONV_1MS_US * CLK_MHZ;
   localparam int CONV_500US_CYC = CONV_500US_US * CLK_MHZ;
   localparam int TMR_W = 20;

endpackage : ccr_pkg

// ---- hw/ccr_sync.sv ----
/*
 * ccr_sync: two-flop synchroniser for a vector of independent levels.
 * Assumes each bit is a level or toggle that stays stable for at least
 * two destination clock edges.
 */
`timescale 1ns/1ps
`default_nettype none

module ccr_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // data
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_q;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         meta_q <= '0;
         sync_out <= '0;
      end else begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end

endmodule : ccr_sync

`default_nettype wire

// ---- hw/ccr_regbank.sv ----
/*
 * ccr_regbank: host-visible register bank of the charge pump converter.
 * The serial decoder hands over byte accesses on link_clk; they cross to
 * ref_clk by a toggle handshake. Comparator and ADC pins are asynchronous
 * and pass two flops. ADC data must be stable while adc_done is high.
 */
`timescale 1ns/1ps
`default_nettype none

// Function
// - status bit 0 latches charge state, 1 when charging requested.
// - status bit 1 latches input overvoltage comparator.
// - status bit 2 latches ADC conversion completion.
// - status bit 3 latches thermal shutdown comparator.
// - status bit 4 latches thermal warning comparator.
// - status bit 5 latches overcurrent when current reading is full scale.
// - status bit 6 latches divide-by-two mode threshold comparator.
// - status bit 7 latches regulator current clamp.
// - input voltage result register, read-only, resets to zero.
// - remote current result register, read-only, resets to zero.
// - die temperature result register, read-only, resets to zero.
// - command 1 bits 3:0 mode threshold code, resets 0011.
// - command 1 bits 6:4 clamp threshold code, resets 111; bit 7 reads 0.
// - command 2 bit 0 unused, reads 1.
// - command 2 bit 1 forces charge-ok output level, resets 0.
// - command 2 bit 2 set disables inverted clock output.
// - command 2 bits 4:3 select automatic conversion interval, reset 2 ms.
// - command 2 bits 7:5 hold divide-by-two entry delay code.
// - command 3 bits 1:0 select regulator output voltage.
// - command 3 reset value depends on regulator variant; bits 7:4 read 0.
// - command 3 bit 2 requests one conversion, only with manual mode set.
// - command 3 bit 3 selects manual mode, suspending automatic conversions.
module ccr_regbank
   import ccr_pkg::*;
#(
   parameter bit VARIANT_18V = 1'b0,
   parameter logic [7:0] REVISION = 8'h5A, // arbitrary value
   parameter int CONV_10MS_CYCLES = CONV_10MS_CYC,
   parameter int CONV_2MS_CYCLES = CONV_2MS_CYC,
   parameter int CONV_1MS_CYCLES = CONV_1MS_CYC,
   parameter int CONV_500US_CYCLES = CONV_500US_CYC
) (
   // clocks and reset
   input wire logic ref_clk,
   input wire logic link_clk,
   input wire logic reset_n,
   // register access from the serial decoder, link_clk domain
   input wire logic link_req,
   input wire logic link_we,
   input wire logic [7:0] link_addr,
   input wire logic [7:0] link_wdata,
   output logic link_ready,
   output logic link_done,
   output logic [7:0] link_rdata,
   // live comparator pins, asynchronous
   input wire logic charging_requested,
   input wire logic overvoltage_cmp,
   input wire logic thermal_shutdown,
   input wire logic thermal_warning_cmp,
   input wire logic mode_threshold_cmp,
   input wire logic regulator_clamp_live,
   input wire logic [3:0] clock_ratio_factor,
   // ADC, asynchronous results
   output logic adc_start,
   input wire logic adc_done,
   input wire logic [7:0] adc_vin,
   input wire logic [7:0] adc_iin,
   input wire logic [7:0] adc_temp,
   // control outputs
   output logic charge_ok_output_out,
   output logic charge_ok_output_oe,
   output logic inverted_clock_disable,
   output logic [3:0] mode_threshold_code,
   output logic [2:0] clamp_threshold_code,
   output logic [2:0] div2_delay_code,
   output logic [1:0] regulator_voltage_select
);

   localparam logic [7:0] RST_CMD3 = VARIANT_18V ? RST_CMD3_V18 : RST_CMD3_V25;
   localparam int PIN_W = 6 + 4 + 1 + 24;

   // link domain
   logic req_tgl_q, we_q, busy_q, ack_sync, ack_seen_q;
   logic [7:0] addr_q, wdata_q, rdata_hold_q;

   // ref domain
   logic req_sync, req_seen_q, acc_stb, wr_stb, rd_stb, ack_tgl_q;
   logic [7:0] rdata_q, rd_mux;

   logic [PIN_W-1:0] pin_raw, pin_s;
   logic [7:0] sense_cmp, vin_s, iin_s, temp_s;
   logic [3:0] ratio_s;
   logic done_s, done_prev_q, done_evt;

   logic [7:0] status_q, event_q, sense_prev_q, sense_now, status_set, event_set;
   logic [7:0] vin_q, iin_q, temp_q, cmd1_q, cmd2_q, cmd3_q;
   logic conv_busy_q, start_q, start_d, oc_evt;
   logic [TMR_W-1:0] tmr_q, interval;

   // link side: take one request at a time, hold it until the ack returns
   always_ff @(posedge link_clk or negedge reset_n) begin
      if (!reset_n) begin
         req_tgl_q <= 1'b0;
         we_q <= 1'b0;
         addr_q <= 8'h00;
         wdata_q <= 8'h00;
         busy_q <= 1'b0;
      end else if (!busy_q && link_req) begin
         req_tgl_q <= ~req_tgl_q;
         we_q <= link_we;
         addr_q <= link_addr;
         wdata_q <= link_wdata;
         busy_q <= 1'b1;
      end else if (busy_q && (ack_sync != ack_seen_q)) begin
         busy_q <= 1'b0;
      end
   end

   always_ff @(posedge link_clk or negedge reset_n) begin
      if (!reset_n) begin
         ack_seen_q <= 1'b0;
         rdata_hold_q <= 8'h00;
         link_done <= 1'b0;
      end else begin
         ack_seen_q <= ack_sync;
         link_done <= busy_q && (ack_sync != ack_seen_q);
         // rdata_q is stable since the ack toggled, so it is safe to take here
         if (busy_q && (ack_sync != ack_seen_q)) begin
            rdata_hold_q <= rdata_q;
         end
      end
   end

   assign link_ready = ~busy_q;
   assign link_rdata = rdata_hold_q;

   ccr_sync #(.WIDTH(1)) u_ack_sync (
      .clk(link_clk),
      .reset_n(reset_n),
      .async_in(ack_tgl_q),
      .sync_out(ack_sync)
   );

   // ref side: a toggle edge is one access; addr/we/wdata held by link side
   ccr_sync #(.WIDTH(1)) u_req_sync (
      .clk(ref_clk),
      .reset_n(reset_n),
      .async_in(req_tgl_q),
      .sync_out(req_sync)
   );

   assign acc_stb = req_sync ^ req_seen_q;
   assign wr_stb = acc_stb & we_q;
   assign rd_stb = acc_stb & ~we_q;

   // analog pins
   assign pin_raw = {charging_requested, overvoltage_cmp, thermal_shutdown,
                     thermal_warning_cmp, mode_threshold_cmp, regulator_clamp_live,
                     clock_ratio_factor, adc_done, adc_vin, adc_iin, adc_temp};

   ccr_sync #(
      .WIDTH(PIN_W)
   ) u_pin_sync (
      .clk(ref_clk),
      .reset_n(reset_n),
      .async_in(pin_raw),
      .sync_out(pin_s)
   );

   assign {sense_cmp[ST_CHARGE], sense_cmp[ST_OVP], sense_cmp[ST_TSD], sense_cmp[ST_WARN],
           sense_cmp[ST_VTH], sense_cmp[ST_CLAMP], ratio_s, done_s, vin_s, iin_s,
           temp_s} = pin_s;
   assign sense_cmp[ST_CONV] = 1'b0;
   assign sense_cmp[ST_OC] = 1'b0;

   assign done_evt = done_s & ~done_prev_q;

   // results load on the synced done edge
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         done_prev_q <= 1'b0;
         vin_q <= RST_ZERO;
         iin_q <= RST_ZERO;
         temp_q <= RST_ZERO;
      end else begin
         done_prev_q <= done_s;
         if (done_evt) begin
            vin_q <= vin_s;
            iin_q <= iin_s;
            temp_q <= temp_s;
         end
      end
   end

   assign oc_evt = done_evt && (iin_s == ADC_FULL_SCALE);

   always_comb begin
      sense_now = sense_cmp;
      sense_now[ST_CONV] = conv_busy_q;
      sense_now[ST_OC] = (iin_q == ADC_FULL_SCALE);
      status_set = sense_cmp;
      status_set[ST_CONV] = done_evt;
      status_set[ST_OC] = oc_evt | (iin_q == ADC_FULL_SCALE);
   end

   // sticky status; a read clears, a live set wins
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         status_q <= RST_ZERO;
      end else if (rd_stb && (addr_q == OFS_STATUS)) begin
         status_q <= status_set;
      end else begin
         status_q <= status_q | status_set;
      end
   end

   // event flags: any change of a live bit, conversion end for bit 2
   always_comb begin
      event_set = sense_now ^ sense_prev_q;
      event_set[ST_CONV] = done_evt;
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         sense_prev_q <= RST_ZERO;
         event_q <= RST_ZERO;
      end else begin
         sense_prev_q <= sense_now;
         if (rd_stb && (addr_q == OFS_EVENT)) begin
            event_q <= event_set;
         end else begin
            event_q <= event_q | event_set;
         end
      end
   end

   // commands 1 and 2; command 1 bit 7 never stored, command 2 bit 0 pinned
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         cmd1_q <= RST_CMD1;
         cmd2_q <= RST_CMD2;
      end else if (wr_stb) begin
         if (addr_q == OFS_CMD1) begin
            cmd1_q <= wdata_q & CMD1_MASK;
         end
         if (addr_q == OFS_CMD2) begin
            cmd2_q <= wdata_q | CMD2_FIXED_ONE;
         end
      end
   end

   // command 3; request bit clears itself once taken
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         cmd3_q <= RST_CMD3;
      end else if (wr_stb && (addr_q == OFS_CMD3)) begin
         cmd3_q <= wdata_q & CMD3_MASK;
         // request only kept when manual mode is set
         cmd3_q[CMD3_CONVR_BIT] <= wdata_q[CMD3_CONVR_BIT] & wdata_q[CMD3_CONVM_BIT];
      end else if (start_d && cmd3_q[CMD3_CONVM_BIT]) begin
         cmd3_q[CMD3_CONVR_BIT] <= 1'b0;
      end
   end

   always_comb begin
      case (cmd2_q[CMD2_CONVD_LSB +: 2])
         CONVD_10MS: interval = TMR_W'(CONV_10MS_CYCLES - 1);
         CONVD_2MS: interval = TMR_W'(CONV_2MS_CYCLES - 1);
         CONVD_1MS: interval = TMR_W'(CONV_1MS_CYCLES - 1);
         CONVD_500US: interval = TMR_W'(CONV_500US_CYCLES - 1);
         default: interval = TMR_W'(CONV_2MS_CYCLES - 1);
      endcase
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         tmr_q <= '0;
      end else if (cmd3_q[CMD3_CONVM_BIT] || tmr_q >= interval) begin
         tmr_q <= '0;
      end else begin
         tmr_q <= tmr_q + 1'b1;
      end
   end

   // start source; a tick during a busy conversion is dropped
   always_comb begin
      if (conv_busy_q || start_q) begin
         start_d = 1'b0;
      end else if (cmd3_q[CMD3_CONVM_BIT]) begin
         start_d = cmd3_q[CMD3_CONVR_BIT];
      end else begin
         start_d = (tmr_q >= interval);
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         start_q <= 1'b0;
         conv_busy_q <= 1'b0;
      end else begin
         start_q <= start_d;
         if (start_d) begin
            conv_busy_q <= 1'b1;
         end else if (done_evt) begin
            conv_busy_q <= 1'b0;
         end
      end
   end

   assign adc_start = start_q;

   // read mux: fixed bits come from the stored masks
   always_comb begin
      case (addr_q)
         OFS_STATUS: rd_mux = status_q;
         OFS_VIN: rd_mux = vin_q;
         OFS_IIN: rd_mux = iin_q;
         OFS_TEMP: rd_mux = temp_q;
         OFS_CMD1: rd_mux = cmd1_q;
         OFS_CMD2: rd_mux = cmd2_q;
         OFS_CMD3: rd_mux = cmd3_q;
         OFS_SENSE1: rd_mux = sense_now;
         OFS_SENSE2: rd_mux = 8'(ratio_s) << SENSE2_RATIO_LSB;
         OFS_EVENT: rd_mux = event_q;
         OFS_REV: rd_mux = REVISION;
         default: rd_mux = RST_ZERO;
      endcase
   end

   // answer: capture data and toggle the ack back to link_clk on the same edge
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         req_seen_q <= 1'b0;
         rdata_q <= RST_ZERO;
         ack_tgl_q <= 1'b0;
      end else begin
         req_seen_q <= req_sync;
         if (acc_stb) begin
            rdata_q <= we_q ? RST_ZERO : rd_mux;
            ack_tgl_q <= ~ack_tgl_q;
         end
      end
   end

   // open drain: pulled low only while the force bit is clear
   assign charge_ok_output_out = 1'b0;
   assign charge_ok_output_oe = ~cmd2_q[CMD2_FORCE_BIT];
   assign inverted_clock_disable = cmd2_q[CMD2_CLKDIS_BIT];
   assign mode_threshold_code = cmd1_q[CMD1_VTH_LSB +: 4];
   assign clamp_threshold_code = cmd1_q[CMD1_VCL_LSB +: 3];
   assign div2_delay_code = cmd2_q[CMD2_DIV2_LSB +: 3];
   assign regulator_voltage_select = cmd3_q[CMD3_VSEL_LSB +: 2];

endmodule : ccr_regbank

`default_nettype wire

// ---- verification/ccr_host_model.sv ----
/*
 * ccr_host_model: requester on the link port, one access per req_tgl flip.
 * Assumes the bench holds the cmd_ fields steady while a flip is pending.
 */
`timescale 1ns/1ps
`default_nettype none

module ccr_host_model (
   // clock and reset
   input wire logic link_clk,
   input wire logic reset_n,
   // bench side
   input wire logic req_tgl,
   input wire logic cmd_we,
   input wire logic [7:0] cmd_addr,
   input wire logic [7:0] cmd_wdata,
   output logic ack_tgl,
   output logic [7:0] rd_q,
   // link port
   output logic link_req,
   output logic link_we,
   output logic [7:0] link_addr,
   output logic [7:0] link_wdata,
   input wire logic link_ready,
   input wire logic link_done,
   input wire logic [7:0] link_rdata
);
   logic seen_q;
   logic wait_q;

   // request held until taken; released addr and wdata lines flip so a stale value never passes
   always_ff @(posedge link_clk or negedge reset_n) begin
      if (!reset_n) begin
         {link_req, link_we, link_addr, link_wdata, seen_q, wait_q, ack_tgl, rd_q} <= '0;
      end else if (link_req && link_ready) begin
         link_req <= 1'b0;
         link_addr <= ~link_addr;
         link_wdata <= ~link_wdata;
         wait_q <= 1'b1;
      end else if (wait_q && link_done) begin
         wait_q <= 1'b0;
         rd_q <= link_rdata;
         ack_tgl <= ~ack_tgl;
      end else if (!link_req && !wait_q && req_tgl != seen_q) begin
         seen_q <= req_tgl;
         link_req <= 1'b1;
         link_we <= cmd_we;
         link_addr <= cmd_addr;
         link_wdata <= cmd_wdata;
      end
   end
endmodule : ccr_host_model
`default_nettype wire

// ---- verification/ccr_regbank_properties.sv ----
/*
 * ccr_regbank_properties: port-level checks of the register bank.
 * Assumes it is bound to ccr_regbank and sees only its ports.
 */
`timescale 1ns/1ps
`default_nettype none

module ccr_regbank_properties
   import ccr_pkg::*;
#(
   parameter bit VARIANT_18V = 1'b0
) (
   // clocks and reset
   input wire logic ref_clk,
   input wire logic link_clk,
   input wire logic reset_n,
   // link access
   input wire logic link_req,
   input wire logic link_we,
   input wire logic [7:0] link_addr,
   input wire logic [7:0] link_wdata,
   input wire logic link_ready,
   input wire logic link_done,
   input wire logic [7:0] link_rdata,
   // outputs
   input wire logic adc_start,
   input wire logic charge_ok_output_out,
   input wire logic charge_ok_output_oe,
   input wire logic inverted_clock_disable,
   input wire logic [3:0] mode_threshold_code,
   input wire logic [2:0] clamp_threshold_code,
   input wire logic [2:0] div2_delay_code,
   input wire logic [1:0] regulator_voltage_select
);
   // access in flight, kept from the edge that took it
   logic cap_we_q;
   logic [7:0] cap_addr_q;
   logic [7:0] cap_wdata_q;

   always_ff @(posedge link_clk or negedge reset_n) begin
      if (!reset_n) begin
         {cap_we_q, cap_addr_q, cap_wdata_q} <= '0;
      end else if (link_req && link_ready) begin
         {cap_we_q, cap_addr_q, cap_wdata_q} <= {link_we, link_addr, link_wdata};
      end
   end

   sequence s_take;
      link_req && link_ready;
   endsequence
   sequence s_wr_done(logic [7:0] a);
      link_done && cap_we_q && cap_addr_q == a;
   endsequence

   property p_answer;
      @(posedge link_clk) disable iff (!reset_n) s_take |-> ##[2:12] link_done;
   endproperty
   a_answer: assert property (p_answer) else $error("access not answered");
   property p_cmd1;
      @(posedge link_clk) disable iff (!reset_n)
         s_wr_done(OFS_CMD1) |-> {clamp_threshold_code, mode_threshold_code} == cap_wdata_q[6:0];
   endproperty
   a_cmd1: assert property (p_cmd1) else $error("threshold codes wrong");
   property p_cmd2;
      @(posedge link_clk) disable iff (!reset_n) s_wr_done(OFS_CMD2) |->
         div2_delay_code == cap_wdata_q[7:5] && inverted_clock_disable == cap_wdata_q[2]
         && charge_ok_output_oe == !cap_wdata_q[1];
   endproperty
   a_cmd2: assert property (p_cmd2) else $error("command 2 outputs wrong");
   property p_cmd3;
      @(posedge link_clk) disable iff (!reset_n)
         s_wr_done(OFS_CMD3) |-> regulator_voltage_select == cap_wdata_q[1:0];
   endproperty
   a_cmd3: assert property (p_cmd3) else $error("voltage select wrong");
   property p_unmapped;
      @(posedge link_clk) disable iff (!reset_n)
         link_done && !cap_we_q && cap_addr_q > OFS_REV |-> link_rdata == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_rst_vals;
      @(posedge ref_clk) disable iff (!reset_n) $rose(reset_n) |->
         {clamp_threshold_code, mode_threshold_code} == RST_CMD1[6:0]
         && div2_delay_code == RST_CMD2[7:5] && inverted_clock_disable == RST_CMD2[2]
         && regulator_voltage_select == (VARIANT_18V ? RST_CMD3_V18[1:0] : RST_CMD3_V25[1:0]);
   endproperty
   a_rst_vals: assert property (p_rst_vals) else $error("reset codes wrong");
   property p_out_low;
      @(posedge ref_clk) disable iff (!reset_n) charge_ok_output_out == 1'b0;
   endproperty
   a_out_low: assert property (p_out_low) else $error("open drain driven high");
   property p_adc_pulse;
      @(posedge ref_clk) disable iff (!reset_n) adc_start |=> !adc_start [*4];
   endproperty
   a_adc_pulse: assert property (p_adc_pulse) else $error("start repeated");
endmodule : ccr_regbank_properties

bind ccr_regbank ccr_regbank_properties #(.VARIANT_18V(VARIANT_18V)) u_props (
   .ref_clk, .link_clk, .reset_n, .link_req, .link_we, .link_addr, .link_wdata,
   .link_ready, .link_done, .link_rdata, .adc_start, .charge_ok_output_out,
   .charge_ok_output_oe, .inverted_clock_disable, .mode_threshold_code,
   .clamp_threshold_code, .div2_delay_code, .regulator_voltage_select);
`default_nettype wire

// ---- verification/converter_control_register_map_bench.sv ----
/*
 * converter_control_register_map_bench: self-checking bench of ccr_regbank.
 * Assumes ccr_host_model on the link and the behavioural ADC modelled here.
 */
`timescale 1ns/1ps
`default_nettype none

module converter_control_register_map_bench
   import ccr_pkg::*;
;
   localparam logic [7:0] REV = 8'h3C; // arbitrary value
   localparam int IVL [4] = '{2000, 1600, 1200, 800};
   logic ref_clk, link_clk, reset_n, req_tgl, cmd_we, ack_tgl, link_req, link_we;
   logic link_ready, link_done, adc_start, adc_done, charge_ok_output_out;
   logic charge_ok_output_oe, inverted_clock_disable;
   logic [7:0] cmd_addr, cmd_wdata, rd_q, link_addr, link_wdata, link_rdata, r, o;
   logic [7:0] adc_vin, adc_iin, adc_temp, vin_v, iin_v, temp_v;
   logic [5:0] cmp_v;
   logic [3:0] mode_threshold_code;
   logic [2:0] clamp_threshold_code, div2_delay_code;
   logic [1:0] regulator_voltage_select;
   int compares, miscompares, starts, last_start, cyc, adc_cnt;

   always #10 ref_clk = ~ref_clk;
   initial begin
      link_clk = 1'b0;
      #7;
      forever #80 link_clk = ~link_clk;
   end

   ccr_regbank #(.REVISION(REV), .CONV_10MS_CYCLES(IVL[0]), .CONV_2MS_CYCLES(IVL[1]),
      .CONV_1MS_CYCLES(IVL[2]), .CONV_500US_CYCLES(IVL[3])) DUT (
      .ref_clk, .link_clk, .reset_n, .link_req, .link_we, .link_addr, .link_wdata,
      .link_ready, .link_done, .link_rdata, .charging_requested(cmp_v[0]),
      .overvoltage_cmp(cmp_v[1]), .thermal_shutdown(cmp_v[2]),
      .thermal_warning_cmp(cmp_v[3]), .mode_threshold_cmp(cmp_v[4]),
      .regulator_clamp_live(cmp_v[5]), .clock_ratio_factor(4'hA), .adc_start,
      .adc_done, .adc_vin, .adc_iin, .adc_temp, .charge_ok_output_out,
      .charge_ok_output_oe, .inverted_clock_disable, .mode_threshold_code,
      .clamp_threshold_code, .div2_delay_code, .regulator_voltage_select);
   ccr_host_model host (.link_clk, .reset_n, .req_tgl, .cmd_we, .cmd_addr, .cmd_wdata,
      .ack_tgl, .rd_q, .link_req, .link_we, .link_addr, .link_wdata, .link_ready,
      .link_done, .link_rdata);

   // results turn over once their hold after the done edge has run out
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (adc_start) begin
         starts <= starts + 1;
         last_start <= cyc;
      end
      adc_cnt <= adc_start ? 1 : (adc_cnt == 14 || adc_cnt == 0) ? 0 : adc_cnt + 1;
      adc_done <= adc_cnt >= 5 && adc_cnt < 12;
      adc_vin <= adc_cnt != 0 ? vin_v : ~vin_v;
      adc_iin <= adc_cnt != 0 ? iin_v : ~iin_v;
      adc_temp <= adc_cnt != 0 ? temp_v : ~temp_v;
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic give_verdict;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : give_verdict

   task automatic acc(input logic we, input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      cmd_we <= we;
      cmd_addr <= a;
      cmd_wdata <= d;
      req_tgl <= ~req_tgl;
      @(posedge ref_clk);
      while (ack_tgl !== req_tgl && n < 400) begin
         @(posedge ref_clk);
         n++;
      end
      if (n == 400) check(8'h00, 8'h01);
      r = rd_q;
   endtask : acc

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      acc(1'b0, a, 8'h00);
      check(r, exp);
   endtask : rd

   task automatic wait_start;
      int s, n;
      s = starts;
      n = 0;
      while (starts == s && n < 3000) begin
         @(posedge ref_clk);
         n++;
      end
      if (n == 3000) check(8'h00, 8'h01);
   endtask : wait_start

   task automatic t_reset;
      logic [7:0] exp [12] = '{8'h00, 8'h00, 8'h00, 8'h00, RST_CMD1, RST_CMD2,
         RST_CMD3_V25, 8'h00, 8'h28, 8'h00, REV, 8'h00};
      for (int a = 0; a < 12; a++) rd(8'(a), exp[a]);
   endtask : t_reset

   task automatic t_rw;
      acc(1'b1, OFS_CMD1, 8'hFF);
      check({1'b0, clamp_threshold_code, mode_threshold_code}, 8'h7F);
      rd(OFS_CMD1, 8'h7F);
      acc(1'b1, OFS_CMD2, 8'hE6);
      o = {div2_delay_code, 2'b00, inverted_clock_disable, ~charge_ok_output_oe, 1'b0};
      check(o, 8'hE6);
      rd(OFS_CMD2, 8'hE7);
      acc(1'b1, OFS_CMD2, 8'h08);
      o = {div2_delay_code, 2'b00, inverted_clock_disable, ~charge_ok_output_oe, 1'b0};
      check(o, 8'h00);
      rd(OFS_CMD2, 8'h09);
      acc(1'b1, OFS_VIN, 8'hAA);
      rd(OFS_VIN, 8'h00);
      acc(1'b1, OFS_REV, 8'hFF);
      rd(OFS_REV, REV);
      for (int v = 0; v < 4; v++) begin
         acc(1'b1, OFS_CMD3, {6'h3C, 2'(v)});
         check({6'h00, regulator_voltage_select}, {6'h00, 2'(v)});
         rd(OFS_CMD3, {6'h00, 2'(v)});
      end
   endtask : t_rw

   task automatic t_manual;
      int s;
      // manual bit set before any request
      acc(1'b1, OFS_CMD3, 8'h08);
      repeat (50) @(posedge ref_clk);
      s = starts;
      repeat (2200) @(posedge ref_clk);
      check(8'(starts - s), 8'h00);
      vin_v <= 8'h5A;
      iin_v <= ADC_FULL_SCALE;
      temp_v <= 8'h33;
      acc(1'b1, OFS_CMD3, 8'h0C);
      repeat (100) @(posedge ref_clk);
      check(8'(starts - s), 8'h01);
      rd(OFS_CMD3, 8'h08);
      rd(OFS_VIN, 8'h5A);
      rd(OFS_IIN, ADC_FULL_SCALE);
      rd(OFS_TEMP, 8'h33);
      rd(OFS_STATUS, 8'h24);
      rd(OFS_STATUS, 8'h20);
   endtask : t_manual

   task automatic t_status;
      int pos [6] = '{0, 1, 3, 4, 6, 7};
      for (int b = 0; b < 6; b++) begin
         cmp_v <= 6'(1 << b);
         repeat (6) @(posedge ref_clk);
         cmp_v <= 6'h00;
         repeat (6) @(posedge ref_clk);
         rd(OFS_STATUS, 8'h20 | 8'(1 << pos[b]));
         rd(OFS_STATUS, 8'h20);
      end
   endtask : t_status

   task automatic t_intervals;
      int t0;
      acc(1'b1, OFS_CMD3, 8'h02);
      for (int c = 0; c < 4; c++) begin
         acc(1'b1, OFS_CMD2, {3'b001, 2'(c), 3'b001});
         wait_start;
         wait_start;
         t0 = last_start;
         wait_start;
         t0 = last_start - t0;
         check(8'(t0 >= IVL[c] && t0 <= IVL[c] + 40), 8'h01);
      end
   endtask : t_intervals

   initial begin
      ref_clk = 1'b0;
      reset_n = 1'b0;
      {req_tgl, cmd_we, cmd_addr, cmd_wdata, cmp_v} = '0;
      {adc_done, adc_vin, adc_iin, adc_temp, vin_v, iin_v, temp_v} = '0;
      repeat (6) @(posedge link_clk);
      @(posedge ref_clk);
      reset_n <= 1'b1;
      repeat (2) @(posedge ref_clk);
      t_reset;
      t_rw;
      t_manual;
      t_status;
      t_intervals;
      give_verdict;
   end

   // the whole run needs well under a millisecond of simulated time
   initial begin
      #1500000;
      miscompares++;
      give_verdict;
   end
endmodule : converter_control_register_map_bench
`default_nettype wire
